// [src/erf_top.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Frame FIFO: only committed words are readable, uncommitted ones can rewind
module erf_fifo #(
	parameter int W  = 32,
	parameter int D  = 16,
	parameter int HI = 12
) (
	input  wire logic         clock_i,   // Clock
	input  wire logic         resetn_i,  // Sync reset, active low
	input  wire logic         wvalid_i,  // Push
	output logic              wready_i_n_unused_o, // Space free
	input  wire logic [W-1:0] wdata_i,   // Push data
	input  wire logic         commit_i,  // Frame end, include this push
	input  wire logic         rewind_i,  // Drop uncommitted words
	output logic              rvalid_o,  // Committed word present
	input  wire logic         rready_i,  // Pop
	output logic [W-1:0]      rdata_o,   // Head word
	output logic              hi_o       // Backlog at watermark or near full
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] cp;
		logic [AW:0] rp;
	} erf_fifo_s_t;
	erf_fifo_s_t s_q, s_d;
	logic [W-1:0] mem [D];
	logic [AW:0]  lvl;
	logic [AW:0]  clvl;
	logic         push;
	logic         pop;
	assign lvl = s_q.wp - s_q.rp;
	assign wready_i_n_unused_o = int'(lvl) < D;
	assign push = wvalid_i && wready_i_n_unused_o;
	assign rvalid_o = s_q.rp != s_q.cp;
	assign pop = rvalid_o && rready_i;
	assign rdata_o = mem[s_q.rp[AW-1:0]];
	assign clvl = s_q.cp - s_q.rp;
	// Backlog of whole frames throttles the writer; the near-full term stops an open
	// frame from overflowing, so a frame longer than the buffer can never complete
	assign hi_o = int'(clvl) >= HI || int'(lvl) >= D - 1;
	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wp = s_q.wp + 1'b1;
		if (commit_i)
			s_d.cp = s_d.wp;
		if (rewind_i)
			s_d.wp = s_q.cp;
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
	end
	// Independent write and read ports on one array
	always_ff @(posedge clock_i) begin
		if (push)
			mem[s_q.wp[AW-1:0]] <= wdata_i;
		if (!resetn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule
//////////////////////////////////////////////////////////////////////////////
module erf_top (
	input  wire logic        clock_i,       // 50 MHz clock
	input  wire logic        resetn_i,      // Sync reset, active low
	input  wire logic        half_duplex_i, // Half duplex mode
	input  wire logic        mac_rts_i,     // MAC ready to send
	output logic             mac_rtr_o,     // Ready to receive to MAC
	input  wire logic        mac_valid_i,   // MAC byte strobe
	input  wire logic [7:0]  mac_data_i,    // MAC byte
	input  wire logic        mac_last_i,    // Last byte of frame
	input  wire logic        mac_abort_i,   // Abort current frame
	input  wire logic        mac_coll_i,    // Excessive collisions
	output logic             fr_rts_o,      // Ready to send to framer
	input  wire logic        fr_rtr_i,      // Framer ready to receive
	output logic             fr_valid_o,    // Word strobe to framer
	output logic [31:0]      fr_data_o,     // Word, first byte in [7:0]
	output logic [1:0]       fr_nbytes_o,   // Valid bytes minus one
	output logic             fr_last_o,     // Last word of frame
	output logic             fr_sb_first_o, // First word of a superblock
	output logic [15:0]      fr_crc_o,      // Running CRC incl. this word
	output logic             in_rtr_o,      // Ready to receive to framer
	input  wire logic        fw_valid_i,    // Framer word strobe
	input  wire logic [31:0] fw_data_i,     // Framer word
	input  wire logic        fw_last_i,     // Last word of frame
	input  wire logic        fw_ctrl_i,     // Word is a control code
	input  wire logic        fw_hec_ok_i,   // Header check passed
	output logic             fr_stop_o,     // Stop frame, restart
	output logic             mac_tx_rts_o,  // Ready to send to MAC
	input  wire logic        mac_tx_rtr_i,  // MAC ready to receive
	output logic             mac_tx_valid_o, // Byte strobe to MAC
	output logic [7:0]       mac_tx_data_o, // Byte to MAC
	output logic             mac_tx_last_o  // Last byte of frame
);
	typedef struct packed {
		erf_pkg::erf_eg_st_t st;
		logic                rtr;
		logic [31:0]         pk;
		logic [1:0]          pn;
		logic                wv;
		logic [34:0]         ww;
		logic                wrew;
		logic                rts;
		logic                fv;
		logic [34:0]         fw;
		logic                fsb;
		logic                fl;
		logic [2:0]          widx;
		logic                ffirst;
		logic [15:0]         crc;
		logic                irtr;
		logic                idrop;
		logic [6:0]          icnt;
		logic                stop;
		logic                trts;
		logic                busy;
		logic [32:0]         tw;
		logic [1:0]          tidx;
		logic                tv;
		logic [7:0]          td;
		logic                tl;
	} erf_s_t;
	erf_s_t s_q, s_d;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ erf_pkg::CRC_POLY) : (r << 1);
		return r;
	endfunction

	logic              eg_hi;
	logic              eg_rv;
	logic [34:0]       eg_rd;
	logic              eg_pop;
	logic              ig_hi;
	logic              ig_rv;
	logic [32:0]       ig_rd;
	logic              ig_pop;
	logic              ig_push;
	logic              ig_bad;
	logic              ig_cmt;
	logic              ig_rew;
	logic              take;
	logic              abort;

	assign eg_pop  = eg_rv && fr_rtr_i && s_q.rts;
	assign take    = s_q.st == erf_pkg::EG_GRANT && s_q.rtr && mac_valid_i;
	assign abort   = s_q.st == erf_pkg::EG_GRANT
		&& (mac_abort_i || (half_duplex_i && mac_coll_i));
	assign ig_bad  = fw_valid_i && s_q.irtr && !s_q.idrop && !fw_hec_ok_i;
	assign ig_push = fw_valid_i && s_q.irtr && !s_q.idrop && fw_hec_ok_i
		&& !fw_ctrl_i;
	assign ig_cmt  = fw_valid_i && s_q.irtr && !s_q.idrop && fw_hec_ok_i && fw_last_i
		&& int'(s_q.icnt) + (fw_ctrl_i ? 0 : 4) >= erf_pkg::MIN_FRAME;
	assign ig_rew  = ig_bad || (fw_valid_i && s_q.irtr && !s_q.idrop && fw_hec_ok_i
		&& fw_last_i && !ig_cmt);
	assign ig_pop  = !s_q.busy && ig_rv && mac_tx_rtr_i;

	erf_fifo #(.W(erf_pkg::EG_W), .D(erf_pkg::DEPTH), .HI(erf_pkg::HI_WM)) u_eg (
		.clock_i             (clock_i),
		.resetn_i            (resetn_i),
		.wvalid_i            (s_q.wv),
		.wready_i_n_unused_o (),
		.wdata_i             (s_q.ww),
		.commit_i            (s_q.wv && s_q.ww[34]),
		.rewind_i            (s_q.wrew),
		.rvalid_o            (eg_rv),
		.rready_i            (eg_pop),
		.rdata_o             (eg_rd),
		.hi_o                (eg_hi)
	);
	erf_fifo #(.W(erf_pkg::IG_W), .D(erf_pkg::DEPTH), .HI(erf_pkg::HI_WM)) u_ig (
		.clock_i             (clock_i),
		.resetn_i            (resetn_i),
		.wvalid_i            (ig_push),
		.wready_i_n_unused_o (),
		.wdata_i             ({fw_last_i, fw_data_i}),
		.commit_i            (ig_cmt),
		.rewind_i            (ig_rew),
		.rvalid_o            (ig_rv),
		.rready_i            (ig_pop),
		.rdata_o             (ig_rd),
		.hi_o                (ig_hi)
	);

	always_comb begin
		s_d = s_q;
		s_d.wv = 1'b0;
		s_d.wrew = 1'b0;
		s_d.fv = 1'b0;
		s_d.fl = 1'b0;
		s_d.fsb = 1'b0;
		s_d.stop = 1'b0;
		s_d.tv = 1'b0;
		//////////////////////////////////////////////////////////////////////
		// Egress: MAC bytes packed into words
		case (s_q.st)
			erf_pkg::EG_IDLE: begin
				if (mac_rts_i && !eg_hi)
					s_d.st = erf_pkg::EG_GRANT;
			end
			erf_pkg::EG_GRANT: begin
				if (abort) begin
					s_d.wrew = 1'b1;
					s_d.pn = 2'h0;
					s_d.st = erf_pkg::EG_DROP;
				end else if (take) begin
					s_d.pk[s_q.pn*8 +: 8] = mac_data_i;
					s_d.pn = s_q.pn + 2'h1;
					if (s_q.pn == 2'h3 || mac_last_i) begin
						s_d.wv = 1'b1;
						s_d.ww = {mac_last_i, s_q.pn, s_d.pk};
						s_d.pn = 2'h0;
					end
					if (mac_last_i)
						s_d.st = erf_pkg::EG_IDLE;
				end
			end
			erf_pkg::EG_DROP: begin
				if (!mac_rts_i)
					s_d.st = erf_pkg::EG_IDLE;
			end
			default: s_d.st = erf_pkg::EG_IDLE;
		endcase
		s_d.rtr = s_d.st == erf_pkg::EG_GRANT && !eg_hi;
		//////////////////////////////////////////////////////////////////////
		// Egress: words to the framer
		s_d.rts = eg_rv;
		if (eg_pop) begin
			s_d.fv = 1'b1;
			s_d.fw = eg_rd;
			s_d.fl = eg_rd[34];
			s_d.widx = s_q.ffirst ? 3'h0 : s_q.widx + 3'h1;
			s_d.fsb = s_d.widx == 3'(erf_pkg::SB_WORDS - 8);
			s_d.crc = s_q.ffirst ? erf_pkg::CRC_INIT : s_q.crc;
			for (int i = 0; i < 4; i++)
				if (i <= int'(eg_rd[33:32]))
					s_d.crc = crc_byte(s_d.crc, eg_rd[i*8 +: 8]);
			s_d.ffirst = eg_rd[34];
		end
		//////////////////////////////////////////////////////////////////////
		// Ingress: framer words checked and stored
		s_d.irtr = !ig_hi;
		if (fw_valid_i && s_q.irtr) begin
			if (s_q.idrop) begin
				if (fw_last_i)
					s_d.idrop = 1'b0;
			end else if (ig_bad) begin
				s_d.stop = 1'b1;
				s_d.idrop = !fw_last_i;
				s_d.icnt = 7'h00;
			end else if (fw_last_i) begin
				s_d.icnt = 7'h00;
			end else if (ig_push && int'(s_q.icnt) < erf_pkg::MIN_FRAME) begin
				s_d.icnt = s_q.icnt + 7'h04;
			end
		end
		//////////////////////////////////////////////////////////////////////
		// Ingress: words unpacked into bytes for the MAC
		s_d.trts = ig_rv;
		if (ig_pop) begin
			s_d.busy = 1'b1;
			s_d.tw = ig_rd;
			s_d.tidx = 2'h0;
		end
		if (s_q.busy) begin
			s_d.tv = 1'b1;
			s_d.td = s_q.tw[s_q.tidx*8 +: 8];
			s_d.tl = s_q.tw[32] && s_q.tidx == 2'h3;
			s_d.tidx = s_q.tidx + 2'h1;
			if (s_q.tidx == 2'h3)
				s_d.busy = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.ffirst <= 1'b1;
			s_q.crc <= erf_pkg::CRC_INIT;
		end else begin
			s_q <= s_d;
		end
	end

	assign mac_rtr_o      = s_q.rtr;
	assign fr_rts_o       = s_q.rts;
	assign fr_valid_o     = s_q.fv;
	assign fr_data_o      = s_q.fw[31:0];
	assign fr_nbytes_o    = s_q.fw[33:32];
	assign fr_last_o      = s_q.fl;
	assign fr_sb_first_o  = s_q.fsb;
	assign fr_crc_o       = s_q.crc;
	assign in_rtr_o       = s_q.irtr;
	assign fr_stop_o      = s_q.stop;
	assign mac_tx_rts_o   = s_q.trts;
	assign mac_tx_valid_o = s_q.tv;
	assign mac_tx_data_o  = s_q.td;
	assign mac_tx_last_o  = s_q.tl;
endmodule

// [src/erf_pkg.sv]
package erf_pkg;
	localparam int          DEPTH     = 16;
	localparam int          HI_WM     = 12;
	localparam int          MIN_FRAME = 64;
	localparam int          SB_WORDS  = 8;
	localparam int          EG_W      = 35;
	localparam int          IG_W      = 33;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	typedef enum logic [1:0] {
		EG_IDLE  = 2'h0,
		EG_GRANT = 2'h1,
		EG_DROP  = 2'h3
	} erf_eg_st_t;
endpackage

// [tb/erf_props.sv]
`timescale 1ns/1ps
module erf_props (
	input wire logic clock_i,        // Clock
	input wire logic resetn_i,       // Reset
	input wire logic half_duplex_i,  // Mode
	input wire logic mac_rts_i,      // MAC rts
	input wire logic mac_rtr_o,      // MAC rtr
	input wire logic mac_abort_i,    // Abort
	input wire logic mac_coll_i,     // Collision
	input wire logic fr_rtr_i,       // Framer rtr
	input wire logic fr_rts_o,       // Framer rts
	input wire logic fr_valid_o,     // Word out
	input wire logic fr_last_o,      // Last word
	input wire logic fw_valid_i,     // Word in
	input wire logic fw_hec_ok_i,    // Header ok
	input wire logic in_rtr_o,       // Ingress rtr
	input wire logic fr_stop_o,      // Stop
	input wire logic mac_tx_rtr_i,   // MAC ready
	input wire logic mac_tx_valid_o  // Byte out
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	property p_rtr; $rose(mac_rtr_o) |-> $past(mac_rts_i); endproperty
	a_rtr: assert property (p_rtr) else $error("rtr without rts");
	property p_ab; mac_abort_i && mac_rtr_o |-> ##[1:2] !mac_rtr_o; endproperty
	a_ab: assert property (p_ab) else $error("abort ignored");
	property p_col; half_duplex_i && mac_coll_i && mac_rtr_o |-> ##[1:2] !mac_rtr_o; endproperty
	a_col: assert property (p_col) else $error("collision ignored");
	property p_frv; fr_valid_o |-> $past(fr_rtr_i && fr_rts_o); endproperty
	a_frv: assert property (p_frv) else $error("word without rtr");
	property p_last; fr_last_o |-> fr_valid_o; endproperty
	a_last: assert property (p_last) else $error("last without valid");
	property p_stop; fr_stop_o |-> $past(fw_valid_i && in_rtr_o && !fw_hec_ok_i); endproperty
	a_stop: assert property (p_stop) else $error("stray stop");
	property p_run; mac_tx_valid_o [*4] |=> !mac_tx_valid_o; endproperty
	a_run: assert property (p_run) else $error("no gap after word");
	property p_txr; $rose(mac_tx_valid_o) |-> $past(mac_tx_rtr_i, 2); endproperty
	a_txr: assert property (p_txr) else $error("byte without ready");
endmodule
bind erf_top erf_props u_props (.clock_i, .resetn_i, .half_duplex_i, .mac_rts_i, .mac_rtr_o,
	.mac_abort_i, .mac_coll_i, .fr_rtr_i, .fr_rts_o, .fr_valid_o, .fr_last_o, .fw_valid_i,
	.fw_hec_ok_i,
	.in_rtr_o, .fr_stop_o, .mac_tx_rtr_i, .mac_tx_valid_o);

// [tb/erf_far.sv]
`timescale 1ns/1ps
module erf_far (
	input  wire logic clock_i, // Clock
	input  wire logic slow_i,  // Stall pattern on
	output logic      rtr_o    // Ready to receive
);
	logic [1:0] cnt_q = 2'h0;
	always_ff @(posedge clock_i) begin
		cnt_q <= cnt_q + 2'h1;
	end
	// Ready half the time when slow, so words wait on the far side
	assign rtr_o = !slow_i || cnt_q[1];
endmodule

// [tb/erf_top_tb.sv]
`timescale 1ns/1ps
module erf_top_tb;
	logic        clock_i = 1'b0, resetn_i = 1'b0, half_duplex_i = 1'b0, mac_rts_i = 1'b0;
	logic        mac_valid_i = 1'b0, mac_last_i = 1'b0, mac_abort_i = 1'b0, mac_coll_i = 1'b0;
	logic        fw_valid_i = 1'b0, fw_last_i = 1'b0, fw_ctrl_i = 1'b0, fw_hec_ok_i = 1'b1;
	logic        slow = 1'b0;
	logic [7:0]  mac_data_i = 8'h00;
	logic [31:0] fw_data_i = 32'h0;
	logic        mac_rtr_o, fr_rts_o, fr_rtr_i, fr_valid_o, fr_last_o, fr_sb_first_o, in_rtr_o;
	logic        fr_stop_o, mac_tx_rts_o, mac_tx_rtr_i, mac_tx_valid_o, mac_tx_last_o;
	logic [31:0] fr_data_o;
	logic [1:0]  fr_nbytes_o;
	logic [15:0] fr_crc_o;
	logic [7:0]  mac_tx_data_o;
	logic [35:0] wq[$];
	logic [8:0]  bq[$];
	logic [15:0] cq[$];
	int          err_count = 0, checks_done = 0, stops = 0;
	always #10 clock_i = ~clock_i;
	erf_top uut (.clock_i, .resetn_i, .half_duplex_i, .mac_rts_i, .mac_rtr_o, .mac_valid_i,
		.mac_data_i, .mac_last_i, .mac_abort_i, .mac_coll_i, .fr_rts_o, .fr_rtr_i, .fr_valid_o,
		.fr_data_o, .fr_nbytes_o, .fr_last_o, .fr_sb_first_o, .fr_crc_o, .in_rtr_o, .fw_valid_i,
		.fw_data_i, .fw_last_i, .fw_ctrl_i, .fw_hec_ok_i, .fr_stop_o, .mac_tx_rts_o,
		.mac_tx_rtr_i, .mac_tx_valid_o, .mac_tx_data_o, .mac_tx_last_o);
	erf_far u_fr (.clock_i, .slow_i(slow), .rtr_o(fr_rtr_i));
	erf_far u_mac (.clock_i, .slow_i(slow), .rtr_o(mac_tx_rtr_i));
	always @(posedge clock_i) begin
		if (fr_valid_o === 1'b1) begin
			wq.push_back({fr_sb_first_o, fr_last_o, fr_nbytes_o, fr_data_o});
			cq.push_back(fr_crc_o);
		end
		if (mac_tx_valid_o === 1'b1) bq.push_back({mac_tx_last_o, mac_tx_data_o});
		if (fr_stop_o === 1'b1) stops++;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [35:0] exp, input logic [35:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Frame check over n bytes counting up from base, most significant bit first
	function automatic logic [15:0] crc_of(input logic [7:0] base, input int n);
		logic [15:0] c;
		c = erf_pkg::CRC_INIT;
		for (int i = 0; i < n; i++) begin
			c = c ^ {base + 8'(i), 8'h00};
			for (int j = 0; j < 8; j++) c = c[15] ? ((c << 1) ^ erf_pkg::CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
	function automatic logic ready(input int k, input int m);
		case (k)
			0: return mac_rtr_o === 1'b1;
			1: return in_rtr_o === 1'b1;
			2: return wq.size() >= m;
			default: return bq.size() >= m;
		endcase
	endfunction
	// Ends at the first edge where the condition holds
	task automatic edge_on(input int k, input int m);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (!ready(k, m) && n < 400);
		if (n >= 400) begin
			err_count++;
			$display("BAD %0t wait ran out", $time);
			final_report();
		end
	endtask
	task automatic put_b(input logic [7:0] b, input logic l);
		mac_valid_i <= 1'b1;
		mac_data_i <= b;
		mac_last_i <= l;
		edge_on(0, 0);
	endtask
	task automatic send_mac(input int n, input logic [7:0] base);
		repeat (2) @(posedge clock_i);
		mac_rts_i <= 1'b1;
		edge_on(0, 0);
		for (int i = 0; i < n; i++) put_b(base + 8'(i), i == n - 1);
		mac_valid_i <= 1'b0;
		mac_last_i <= 1'b0;
		mac_rts_i <= 1'b0;
	endtask
	task automatic send_fw(input int nw, input int bad, input int ctl);
		repeat (2) @(posedge clock_i);
		for (int i = 0; i < nw; i++) begin
			fw_valid_i <= 1'b1;
			fw_data_i <= {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
			fw_last_i <= (i == nw - 1);
			fw_hec_ok_i <= (i != bad);
			fw_ctrl_i <= (i == ctl);
			edge_on(1, 0);
		end
		fw_valid_i <= 1'b0;
		fw_last_i <= 1'b0;
		fw_hec_ok_i <= 1'b1;
		fw_ctrl_i <= 1'b0;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_egress();
		wq.delete();
		cq.delete();
		send_mac(38, 8'h10);
		edge_on(2, 10);
		cmp({4'hB, 32'h13121110}, wq[0]);
		cmp({4'h3, 32'h17161514}, wq[1]);
		cmp({4'hB, 32'h33323130}, wq[8]);
		cmp({4'h5, 32'h3534}, {wq[9][35:32], 16'h0, wq[9][15:0]});
		cmp(36'(crc_of(8'h10, 38)), 36'(cq[9]));
	endtask
	task automatic t_drop();
		half_duplex_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wq.delete();
			repeat (2) @(posedge clock_i);
			mac_rts_i <= 1'b1;
			edge_on(0, 0);
			for (int i = 0; i < 5; i++) put_b(8'hE0, 1'b0);
			mac_valid_i <= 1'b0;
			mac_abort_i <= (k == 0);
			mac_coll_i <= (k == 1);
			@(posedge clock_i);
			mac_abort_i <= 1'b0;
			mac_coll_i <= 1'b0;
			mac_rts_i <= 1'b0;
			send_mac(4, 8'h40);
			edge_on(2, 1);
			cmp({4'hF, 32'h43424140}, wq[0]);
		end
		half_duplex_i <= 1'b0;
		mac_coll_i <= 1'b1;
		wq.delete();
		send_mac(4, 8'h50);
		mac_coll_i <= 1'b0;
		edge_on(2, 1);
		cmp({4'hF, 32'h53525150}, wq[0]);
	endtask
	task automatic t_ingress();
		bq.delete();
		slow <= 1'b1;
		send_fw(15, 99, 99);
		send_fw(16, 99, 99);
		repeat (2) @(posedge clock_i);
		cmp(36'({in_rtr_o, mac_tx_rts_o}), 36'h1);
		edge_on(3, 64);
		repeat (20) @(posedge clock_i);
		cmp(36'(in_rtr_o), 36'h1);
		cmp(36'(bq.size()), 36'h40);
		for (int i = 0; i < 64; i++) cmp({27'h0, i == 63, 8'(i)}, 36'(bq[i]));
		slow <= 1'b0;
	endtask
	task automatic t_hec();
		bq.delete();
		stops = 0;
		send_fw(16, 2, 99);
		send_fw(16, 99, 3);
		repeat (40) @(posedge clock_i);
		cmp(36'(stops), 36'h1);
		cmp(36'(bq.size()), 36'h0);
	endtask
	initial begin
		repeat (10) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_egress();
		t_drop();
		t_ingress();
		t_hec();
		final_report();
	end
endmodule
